//--- hdl/iaa_pkg.sv
/*
 * Shared constants and types of the interrupt acknowledge and
 * arbitration block. Assumes a single 10 MHz system clock.
 */
// How it works
// RL1 - reset sets integration unit arbitration field to F, modules to 0
// RL2 - integration unit field contends for external requests
// RL3 - contention runs on every acknowledge, even with one requester
// RL4 - cycle goes to the external bus only if integration unit wins
// RL5 - no contender ends the acknowledge with a bus error
// RL6 - winning module drives its vector and internal termination
// RL7 - external device answers vector with size ack, or autovector
// RL8 - no external answer in time: bus error, spurious interrupt
// RL9 - chip-select matching enabled only after the cycle is forwarded
// RL10 - internal winner keeps chip selects silent and terminates itself
// RL11 - periodic timer level zero raises no request
// RL12 - same level in integration unit: timer first, then pins
// RL13 - processing starts only at instruction or exception boundary
// RL14 - before acknowledge: stack state, set supervisor, clear trace
// RL15 - function code is 111 during acknowledge
// RL16 - address: bits 23..4 ones, 3..1 level, bit 0 one
// RL17 - acknowledged level latched into the priority mask field
// RL18 - a source contends only when address bits 3..1 match its level
// RL19 - zero winning value: bus error and spurious vector
// RL20 - autovector request gives vector derived from the level
// RL21 - vector becomes vector address loaded into program counter
// RL22 - values rank 1 lowest to 15 highest, highest wins
// RL23 - unique nonzero values give exactly one winner
package iaa_pkg;
    localparam int          NMOD        = 4;
    localparam logic [3:0]  ARB_IU_RST  = 4'hF;
    localparam logic [3:0]  ARB_MOD_RST = 4'h0;
    localparam logic [3:0]  ARB_NONE    = 4'h0;
    localparam logic [2:0]  FC_CPU      = 3'h7;
    localparam logic [19:0] ACK_ADDR_HI = 20'hFFFFF;
    localparam logic [2:0]  MASK_RST    = 3'h7;
    localparam logic [2:0]  LVL_OFF     = 3'h0;
    localparam logic [2:0]  LVL_NMI     = 3'h7;
    localparam logic [7:0]  SPUR_VEC    = 8'h18;
    localparam logic [7:0]  AUTO_BASE   = 8'h18;
    localparam int          CLK_NS      = 100;
    localparam int          BUS_MON_NS  = 6400;
    localparam int          BUS_MON_CYC = BUS_MON_NS / CLK_NS;
    localparam int          MON_W       = 7;

    typedef enum logic [2:0] {
        ST_IDLE, ST_STACK, ST_ACK, ST_ARB, ST_EXT, ST_VECT
    } iaa_state_e;

    // acknowledge cycle as seen on the bus
    typedef struct packed {
        logic        active;
        logic [2:0]  fc;
        logic [23:0] addr;
    } iaa_ack_s;

    // answer of an external device on a forwarded cycle
    typedef struct packed {
        logic       data_size_ack;
        logic       autovector_request;
        logic [7:0] data;
    } iaa_ext_s;

    // status register fields kept here
    typedef struct packed {
        logic       sup;
        logic       traceHigh;
        logic       traceLow;
        logic [2:0] mask;
    } iaa_sr_s;

    // internal module requests
    typedef struct packed {
        logic [NMOD-1:0][2:0] level;
        logic [NMOD-1:0][7:0] vec;
    } iaa_modreq_s;

    typedef struct packed {
        logic                    any;
        logic [3:0]              arb;
        logic                    iu;
        logic [$clog2(NMOD)-1:0] idx;
    } iaa_win_s;
endpackage

//--- hdl/iaa_arbiter.sv
/*
 * Arbitration contention among internal modules and the integration
 * unit. Purely combinational; inputs stable during the contention cycle.
 */
`timescale 1ns/1ps
module iaa_arbiter
    import iaa_pkg::*;
(
    input  wire logic [2:0]            ackLevel,
    input  wire logic [NMOD-1:0][2:0]  modLevel,
    input  wire logic [NMOD-1:0][3:0]  modArb,
    input  wire logic [2:0]            iuLevel,
    input  wire logic [3:0]            iuArb,
    output iaa_win_s                   win
);
    always_comb begin
        win = '0;
        // integration unit contends for pins and timer
        if (iuLevel == ackLevel && iuLevel != LVL_OFF) begin // [RL2] [RL18]
            win.any = 1'b1;
            win.arb = iuArb;
            win.iu  = 1'b1;
        end
        for (int i = 0; i < NMOD; i++) begin
            if (modLevel[i] == ackLevel && modLevel[i] != LVL_OFF) begin // [RL18]
                // strict compare keeps first on a tie
                if (!win.any || modArb[i] > win.arb) begin // [RL22] [RL23]
                    win.any = 1'b1;
                    win.arb = modArb[i];
                    win.iu  = 1'b0;
                    win.idx = i[$clog2(NMOD)-1:0];
                end
            end
        end
    end
endmodule // iaa_arbiter

//--- hdl/iaa_bus_mon.sv
/*
 * Bus monitor for forwarded acknowledge cycles. Counts while the cycle
 * is on the external bus and flags a timeout.
 */
`timescale 1ns/1ps
module iaa_bus_mon
    import iaa_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      timeout
);
    typedef struct packed {
        logic [MON_W-1:0] cnt;
    } iaa_mon_s;

    iaa_mon_s s_q;
    iaa_mon_s s_d;

    localparam logic [MON_W-1:0] LAST = MON_W'(BUS_MON_CYC - 1);

    assign timeout = run && s_q.cnt == LAST; // [RL8]

    always_comb begin
        s_d = s_q;
        if (!run || timeout) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + MON_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // iaa_bus_mon

//--- hdl/iaa_top.sv
/*
 * Interrupt acknowledge sequencer: recognition, state save, CPU space
 * acknowledge cycle, contention, termination and vector fetch address.
 * Assumes all inputs synchronous to sys_clk.
 */
`timescale 1ns/1ps
module iaa_top
    import iaa_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    boundary,
    input  wire logic [7:1]              irqPin_n,
    input  wire logic [2:0]              periodicIrqLevel,
    input  wire logic                    ptTick,
    input  wire logic [7:0]              ptVec,
    input  wire iaa_modreq_s             modReq,
    input  wire logic                    arbWr,
    input  wire logic [2:0]              arbSel,
    input  wire logic [3:0]              arbData,
    input  wire logic                    srWr,
    input  wire iaa_sr_s                 srIn,
    input  wire iaa_ext_s                ext,
    input  wire logic [23:0]             vbr,
    output iaa_ack_s                     ack,
    output iaa_sr_s                      sr,
    output logic                         saveState,
    output logic                         extForward,
    output logic                         csEvalEn,
    output logic                         dataSizeAckInt,
    output logic                         busError,
    output logic                         spurious,
    output logic [7:0]                   dataOut,
    output logic                         dataOe,
    output logic [NMOD-1:0]              modAck,
    output logic [23:0]                  vecAddr,
    output logic                         pcLoad
);
    typedef struct packed {
        iaa_state_e           st;
        logic [2:0]           lvl;
        iaa_sr_s              sr;
        logic [3:0]           iuArb;
        logic [NMOD-1:0][3:0] modArb;
        logic                 ptPend;
        logic [7:1]           pinA;
        logic [7:1]           pinB;
        iaa_ack_s             ack;
        logic                 fwd;
        logic                 data_size_ack;
        logic                 bus_error_signal;
        logic                 spur;
        logic [7:0]           vec;
        logic [7:0]           dout;
        logic                 dOe;
        logic [NMOD-1:0]      modAck;
        logic [23:0]          vecAddr;
        logic                 pcLoad;
    } iaa_main_s;

    iaa_main_s  s_q;
    iaa_main_s  s_d;
    logic [1:0] rstSh_q;
    logic       rstn;
    logic [2:0] pinLvl;
    logic [2:0] iuLvl;
    logic [2:0] pendLvl;
    iaa_win_s   win;
    logic       monTimeout;

    // highest set level of a one-hot-ish request vector
    function automatic logic [2:0] topLevel(input logic [7:1] req);
        topLevel = LVL_OFF;
        for (int i = 1; i <= 7; i++) begin
            if (req[i]) begin
                topLevel = 3'(i);
            end
        end
    endfunction

    function automatic logic [2:0] maxLvl(input logic [2:0] a,
                                          input logic [2:0] b);
        maxLvl = (a > b) ? a : b;
    endfunction

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstSh_q <= 2'h0;
        end else begin
            rstSh_q <= {rstSh_q[0], 1'b1};
        end
    end
    assign rstn = rstSh_q[1];

    // pin requests valid after two consecutive low samples
    assign pinLvl = topLevel(s_q.pinA & s_q.pinB);
    assign iuLvl  = maxLvl(s_q.ptPend ? periodicIrqLevel : LVL_OFF,
                           pinLvl);
    always_comb begin
        pendLvl = iuLvl;
        for (int i = 0; i < NMOD; i++) begin
            pendLvl = maxLvl(pendLvl, modReq.level[i]);
        end
    end

    iaa_arbiter u_arb (
        .ackLevel (s_q.ack.addr[3:1]),
        .modLevel (modReq.level),
        .modArb   (s_q.modArb),
        .iuLevel  (iuLvl),
        .iuArb    (s_q.iuArb),
        .win      (win)
    );

    iaa_bus_mon u_mon (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (s_q.fwd),
        .timeout (monTimeout)
    );

    always_comb begin
        s_d        = s_q;
        s_d.pinA   = ~irqPin_n;
        s_d.pinB   = s_q.pinA;
        s_d.pcLoad = 1'b0;
        if (arbWr) begin
            if (arbSel == 3'(NMOD)) begin
                s_d.iuArb = arbData;
            end else if (arbSel < 3'(NMOD)) begin
                s_d.modArb[arbSel[$clog2(NMOD)-1:0]] = arbData;
            end
        end
        if (srWr && s_q.st == ST_IDLE) begin
            s_d.sr = srIn;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (boundary && pendLvl != LVL_OFF &&
                    (pendLvl > s_q.sr.mask || pendLvl == LVL_NMI)) begin // [RL13]
                    s_d.lvl = pendLvl;
                    s_d.st  = ST_STACK;
                end
            end
            ST_STACK: begin
                s_d.sr.sup       = 1'b1; // [RL14]
                s_d.sr.traceHigh = 1'b0; // [RL14]
                s_d.sr.traceLow  = 1'b0; // [RL14]
                s_d.ack.active   = 1'b1;
                s_d.ack.fc       = FC_CPU; // [RL15]
                s_d.ack.addr     = {ACK_ADDR_HI, s_q.lvl, 1'b1}; // [RL16]
                s_d.st           = ST_ACK;
            end
            ST_ACK: begin
                s_d.sr.mask = s_q.ack.addr[3:1]; // [RL17]
                s_d.st      = ST_ARB;
            end
            ST_ARB: begin
                // contention happens on every cycle
                if (!win.any || win.arb == ARB_NONE) begin // [RL3] [RL5] [RL19]
                    s_d.bus_error_signal = 1'b1;
                    s_d.spur = 1'b1;
                    s_d.vec  = SPUR_VEC;
                    s_d.st   = ST_VECT;
                end else if (!win.iu) begin
                    s_d.dout  = modReq.vec[win.idx]; // [RL6] [RL10]
                    s_d.dOe   = 1'b1;
                    s_d.data_size_ack = 1'b1;
                    s_d.vec   = modReq.vec[win.idx];
                    s_d.modAck[win.idx] = 1'b1;
                    s_d.st    = ST_VECT;
                end else if (s_q.ptPend &&
                             periodicIrqLevel == s_q.ack.addr[3:1]) begin // [RL12]
                    s_d.dout   = ptVec;
                    s_d.dOe    = 1'b1;
                    s_d.data_size_ack  = 1'b1;
                    s_d.vec    = ptVec;
                    s_d.ptPend = 1'b0;
                    s_d.st     = ST_VECT;
                end else begin
                    s_d.fwd = 1'b1; // [RL4] [RL9]
                    s_d.st  = ST_EXT;
                end
            end
            ST_EXT: begin
                // external device answers, or the bus monitor times out
                if (ext.data_size_ack) begin // [RL7]
                    s_d.vec = ext.data;
                    s_d.fwd = 1'b0;
                    s_d.st  = ST_VECT;
                end else if (ext.autovector_request) begin // [RL20]
                    s_d.vec = AUTO_BASE + {5'h0, s_q.lvl};
                    s_d.fwd = 1'b0;
                    s_d.st  = ST_VECT;
                end else if (monTimeout) begin // [RL8]
                    s_d.bus_error_signal = 1'b1;
                    s_d.spur = 1'b1;
                    s_d.vec  = SPUR_VEC;
                    s_d.fwd  = 1'b0;
                    s_d.st   = ST_VECT;
                end
            end
            ST_VECT: begin
                s_d.vecAddr = vbr + {14'h0, s_q.vec, 2'h0}; // [RL21]
                s_d.pcLoad  = 1'b1; // [RL21]
                s_d.ack     = '0;
                s_d.data_size_ack   = 1'b0;
                s_d.bus_error_signal    = 1'b0;
                s_d.spur    = 1'b0;
                s_d.dOe     = 1'b0;
                s_d.modAck  = '0;
                s_d.st      = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // timer tick sets, and wins over the clear above
        if (ptTick && periodicIrqLevel != LVL_OFF) begin // [RL11]
            s_d.ptPend = 1'b1;
        end
        if (periodicIrqLevel == LVL_OFF) begin // [RL11]
            s_d.ptPend = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q           <= '0;
            s_q.st        <= ST_IDLE;
            s_q.sr.sup    <= 1'b1;
            s_q.sr.mask   <= MASK_RST;
            s_q.iuArb     <= ARB_IU_RST; // [RL1]
            s_q.modArb    <= {NMOD{ARB_MOD_RST}}; // [RL1]
        end else begin
            s_q <= s_d;
        end
    end

    assign ack            = s_q.ack;
    assign sr             = s_q.sr;
    assign saveState      = s_q.st == ST_STACK; // [RL14]
    assign extForward     = s_q.fwd;
    assign csEvalEn       = s_q.fwd; // [RL9] [RL10]
    assign dataSizeAckInt = s_q.data_size_ack;
    assign busError       = s_q.bus_error_signal;
    assign spurious       = s_q.spur;
    assign dataOut        = s_q.dout;
    assign dataOe         = s_q.dOe;
    assign modAck         = s_q.modAck;
    assign vecAddr        = s_q.vecAddr;
    assign pcLoad         = s_q.pcLoad;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence seqStart;
        s_q.st == ST_IDLE ##1 s_q.st == ST_STACK;
    endsequence
    sequence seqAckUp;
        s_q.st == ST_ACK ##1 s_q.st == ST_ARB;
    endsequence

    chk_arb_reset: assert property ($rose(rstn) |-> // [RL1]
        s_q.iuArb == ARB_IU_RST && s_q.modArb == '0)
        else $error("arbitration fields wrong after reset");
    chk_start_boundary: assert property (seqStart |-> // [RL13]
        $past(boundary))
        else $error("acknowledge started off a boundary");
    chk_stack_bits: assert property (s_q.st == ST_STACK |=> // [RL14]
        sr.sup && !sr.traceHigh && !sr.traceLow && ack.active)
        else $error("state save bits not set");
    chk_ack_addr: assert property (ack.active |-> // [RL15] [RL16]
        ack.fc == FC_CPU && ack.addr[23:4] == ACK_ADDR_HI &&
        ack.addr[0] && ack.addr[3:1] == s_q.lvl)
        else $error("acknowledge cycle encoding wrong");
    chk_mask_latch: assert property (seqAckUp |-> // [RL17]
        sr.mask == s_q.lvl)
        else $error("mask not latched from level");
    chk_no_contend: assert property (s_q.st == ST_ARB && // [RL5] [RL19]
        (!win.any || win.arb == ARB_NONE) |=>
        busError && spurious && s_q.vec == SPUR_VEC)
        else $error("empty contention not ended by bus error");
    chk_fwd_only_iu: assert property ($rose(extForward) |-> // [RL4]
        $past(win.iu) && $past(s_q.st) == ST_ARB)
        else $error("cycle forwarded without unit win");
    chk_int_winner: assert property (s_q.st == ST_ARB && // [RL6] [RL10]
        win.any && !win.iu && win.arb != ARB_NONE |=>
        dataSizeAckInt && dataOe && !csEvalEn)
        else $error("internal winner did not terminate");
    chk_timeout_bus_error_signal: assert property (s_q.fwd && monTimeout && // [RL8]
        !ext.data_size_ack && !ext.autovector_request |=> busError && spurious)
        else $error("timeout did not raise bus error");
    chk_pt_off: assert property (periodicIrqLevel == LVL_OFF |=> // [RL11]
        !s_q.ptPend)
        else $error("timer pending with level zero");
    chk_pc_load: assert property (s_q.st == ST_VECT |=> // [RL21]
        pcLoad &&
        vecAddr == $past(vbr) + {14'h0, $past(s_q.vec), 2'h0})
        else $error("vector address not loaded");
endmodule // iaa_top

//--- tb/iaa_ext_dev.sv
/*
 * Behavioural model of an external interrupting device on the bus.
 * Assumes the acknowledge sequencer forwards cycles via extForward.
 */
`timescale 1ns/1ps
module iaa_ext_dev
    import iaa_pkg::*;
#(
    parameter logic [7:0] DEV_VEC = 8'h77
)(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       req,
    input  wire logic [2:0] level,
    input  wire logic [1:0] mode,
    input  wire logic [3:0] delay,
    input  wire iaa_ack_s   ack,
    input  wire logic       extForward,
    output logic [7:1]      irqPin_n,
    output iaa_ext_s        ext
);
    logic       servedQ;
    logic [3:0] waitQ;

    // pin held low until the matching acknowledge is answered
    always_comb begin
        irqPin_n = 7'h7F;
        if (req && !servedQ && level != 3'h0) begin
            irqPin_n[level] = 1'b0;
        end
    end

    // mode 0 vector with size ack, 1 autovector, 2 silent
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ext     <= '{data_size_ack: 1'b0, autovector_request: 1'b0, data: 8'h5A};
            servedQ <= 1'b0;
            waitQ   <= 4'h0;
        end else begin
            if (!req) begin
                servedQ <= 1'b0;
            end
            if (!extForward) begin
                ext.data_size_ack <= 1'b0;
                ext.autovector_request  <= 1'b0;
                ext.data  <= ~ext.data;
                waitQ     <= 4'h0;
            end else if (req && ack.addr[3:1] == level) begin
                if (waitQ != delay) begin
                    waitQ    <= waitQ + 4'h1;
                    ext.data <= ~ext.data;
                end else if (mode == 2'h0) begin
                    ext.data_size_ack <= 1'b1;
                    ext.data  <= DEV_VEC;
                    servedQ   <= 1'b1;
                end else if (mode == 2'h1) begin
                    ext.autovector_request <= 1'b1;
                    servedQ  <= 1'b1;
                end
            end
        end
    end
endmodule // iaa_ext_dev

//--- tb/iaa_top_test.sv
/*
 * Self-checking bench of the acknowledge sequencer with a device model.
 * Assumes inputs driven on the falling edge of a 10 MHz clock.
 */
`timescale 1ns/1ps
module iaa_top_test;
    import iaa_pkg::*;
    typedef struct packed {
        logic [2:0]  mask;
        logic [11:0] mLvl;
        logic [15:0] mArb;
        logic [3:0]  iuArb;
        logic [2:0]  exLvl;
        logic [1:0]  exMode;
        logic [2:0]  ptLvl;
        logic [2:0]  lvl;
        logic [2:0]  kind;
        logic [7:0]  vec;
        logic [3:0]  mAck;
    } iaa_row_s;

    logic sys_clk, resetn, boundary, ptTick, arbWr, srWr, exReq;
    logic [7:1] irqPin_n;
    logic [2:0] periodicIrqLevel, arbSel, exLvl;
    logic [3:0] arbData;
    logic [1:0] exMode;
    iaa_modreq_s modReq;
    iaa_sr_s srIn, sr;
    iaa_ext_s ext;
    iaa_ack_s ack;
    logic saveState, extForward, csEvalEn, dataSizeAckInt, busError;
    logic spurious, dataOe, pcLoad;
    logic [7:0] dataOut;
    logic [3:0] modAck;
    logic [23:0] vecAddr;
    logic [23:0] vbr = 24'h001000;
    int bad_count = 0;
    int check_count = 0;
    iaa_row_s rows [0:10];

    iaa_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .boundary(boundary),
        .irqPin_n(irqPin_n), .periodicIrqLevel(periodicIrqLevel),
        .ptTick(ptTick), .ptVec(8'h55), .modReq(modReq), .arbWr(arbWr),
        .arbSel(arbSel), .arbData(arbData), .srWr(srWr), .srIn(srIn),
        .ext(ext), .vbr(vbr), .ack(ack), .sr(sr), .saveState(saveState),
        .extForward(extForward), .csEvalEn(csEvalEn),
        .dataSizeAckInt(dataSizeAckInt), .busError(busError),
        .spurious(spurious), .dataOut(dataOut), .dataOe(dataOe),
        .modAck(modAck), .vecAddr(vecAddr), .pcLoad(pcLoad));

    iaa_ext_dev u_dev (.sys_clk(sys_clk), .resetn(resetn), .req(exReq),
        .level(exLvl), .mode(exMode), .delay(4'h2), .ack(ack),
        .extForward(extForward), .irqPin_n(irqPin_n), .ext(ext));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // no sequence may start within 20 cycles
    task automatic quiet();
        bit seen;
        seen = 0;
        repeat (20) begin
            @(negedge sys_clk);
            seen |= saveState;
        end
        chk(!seen, "sequence started while it should not");
    endtask

    task automatic run_row(input iaa_row_s r, input bit wrArb);
        bit fwd, bus_error_signal, spur, dsk, ackOk, cs;
        logic [7:0] dOut;
        logic [3:0] mAck;
        int i;
        {fwd, bus_error_signal, spur, dsk, ackOk, cs} = '0;
        dOut = 8'h00;
        mAck = 4'h0;
        @(negedge sys_clk);
        srWr = 1'b1;
        srIn = {1'b0, 1'b1, 1'b1, r.mask};
        for (i = 0; i < 5; i++) begin
            @(negedge sys_clk);
            srWr = 1'b0;
            arbWr = wrArb;
            arbSel = 3'(i);
            arbData = (i < 4) ? r.mArb[i*4 +: 4] : r.iuArb;
        end
        @(negedge sys_clk);
        arbWr = 1'b0;
        modReq.level = r.mLvl;
        {exLvl, exMode, exReq} = {r.exLvl, r.exMode, r.exLvl != 3'h0};
        periodicIrqLevel = r.ptLvl;
        ptTick = (r.ptLvl != 3'h0);
        @(negedge sys_clk);
        ptTick = 1'b0;
        quiet();
        boundary = 1'b1;
        for (i = 0; i < 300 && pcLoad !== 1'b1; i++) begin
            @(negedge sys_clk);
            if (saveState) boundary = 1'b0;
            if (ack.active && !ackOk) begin
                ackOk = 1;
                chk(ack.fc === FC_CPU, "function code");
                chk(ack.addr === {ACK_ADDR_HI, r.lvl, 1'b1}, "ack addr");
                chk(sr.sup === 1'b1 && {sr.traceHigh, sr.traceLow} === 2'h0,
                    "status not stacked");
            end
            if (csEvalEn) chk(extForward === 1'b1, "early cs");
            fwd |= extForward;
            cs |= csEvalEn;
            bus_error_signal |= busError;
            spur |= spurious;
            mAck |= modAck;
            if (dataSizeAckInt) begin
                dsk = 1;
                dOut = dataOut;
                chk(dataOe === 1'b1, "vector not driven");
            end
        end
        if (pcLoad !== 1'b1) begin
            chk(0, "acknowledge never completed");
            complete_run();
        end
        chk(ackOk, "no acknowledge cycle");
        chk(sr.mask === r.lvl, "mask not latched");
        chk(vecAddr === vbr + {14'h0, r.vec, 2'b00}, "vector addr");
        chk(fwd == (r.kind[0]), "forwarding");
        chk(cs == r.kind[0], "chip-select window");
        chk(bus_error_signal == (r.kind >= 3'h2), "bus error");
        chk(spur == (r.kind >= 3'h2), "spurious");
        chk(dsk == (r.kind == 3'h0), "internal termination");
        chk(mAck === r.mAck, "winner");
        if (r.kind == 3'h0) chk(dOut === r.vec, "vector on bus");
        modReq.level = '0;
        {exReq, periodicIrqLevel} = '0;
        repeat (2) @(negedge sys_clk);
    endtask

    initial begin
        // mask mLvl mArb iu exL mode pt lvl kind vec mAck
        rows = '{
            {3'h0, 12'h018, 16'h0050, 4'hF, 3'h0, 2'h0, 3'h0, 3'h3, 3'h0,
             8'h41, 4'h2},
            {3'h0, 12'h104, 16'h0902, 4'hF, 3'h0, 2'h0, 3'h0, 3'h4, 3'h0,
             8'h42, 4'h4},
            {3'h0, 12'hA10, 16'h0060, 4'hF, 3'h0, 2'h0, 3'h0, 3'h5, 3'h2,
             SPUR_VEC, 4'h0},
            {3'h0, 12'h000, 16'h0000, 4'hF, 3'h2, 2'h0, 3'h0, 3'h2, 3'h1,
             8'h77, 4'h0},
            {3'h0, 12'h000, 16'h0000, 4'hF, 3'h2, 2'h1, 3'h0, 3'h2, 3'h1,
             AUTO_BASE + 8'h02, 4'h0},
            {3'h5, 12'h006, 16'h0004, 4'h3, 3'h6, 2'h0, 3'h0, 3'h6, 3'h0,
             8'h40, 4'h1},
            {3'h5, 12'h006, 16'h0004, 4'h7, 3'h6, 2'h0, 3'h0, 3'h6, 3'h1,
             8'h77, 4'h0},
            {3'h0, 12'h000, 16'h0000, 4'hF, 3'h3, 2'h0, 3'h3, 3'h3, 3'h0,
             8'h55, 4'h0},
            {3'h0, 12'h000, 16'h0000, 4'hF, 3'h3, 2'h0, 3'h0, 3'h3, 3'h1,
             8'h77, 4'h0},
            {3'h7, 12'h1C0, 16'h0100, 4'hF, 3'h0, 2'h0, 3'h0, 3'h7, 3'h0,
             8'h42, 4'h4},
            {3'h0, 12'h000, 16'h0000, 4'hF, 3'h1, 2'h2, 3'h0, 3'h1, 3'h3,
             SPUR_VEC, 4'h0}
        };
        {resetn, boundary, ptTick, arbWr, srWr, exReq} = '0;
        {periodicIrqLevel, arbSel, exLvl, arbData, exMode} = '0;
        srIn = '0;
        modReq.level = '0;
        modReq.vec = {8'h43, 8'h42, 8'h41, 8'h40};
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        foreach (rows[k]) run_row(rows[k], 1'b1);
        // timer at level zero and a masked module stay silent
        srWr = 1'b1;
        srIn = {1'b1, 1'b0, 1'b0, 3'h3};
        @(negedge sys_clk);
        {srWr, ptTick, periodicIrqLevel} = {1'b0, 1'b1, 3'h0};
        modReq.level = 12'h003;
        boundary = 1'b1;
        quiet();
        {ptTick, periodicIrqLevel} = {1'b0, 3'h5};
        quiet();
        {boundary, periodicIrqLevel} = '0;
        modReq.level = '0;
        // reset in mid-cycle while a forwarded cycle is waiting
        srWr = 1'b1;
        srIn = {1'b1, 1'b0, 1'b0, 3'h0};
        @(negedge sys_clk);
        {srWr, exReq, exLvl, exMode} = {1'b0, 1'b1, 3'h1, 2'h2};
        boundary = 1'b1;
        repeat (30) @(negedge sys_clk);
        {resetn, boundary, exReq} = '0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(sr === iaa_sr_s'{sup: 1'b1, traceHigh: 1'b0, traceLow: 1'b0,
            mask: MASK_RST} && ack.active === 1'b0, "reset state");
        run_row({3'h0, 12'h002, 16'h0000, 4'h0, 3'h0, 2'h0, 3'h0, 3'h2,
                 3'h2, SPUR_VEC, 4'h0}, 1'b0);
        run_row({3'h0, 12'h004, 16'h0000, 4'h0, 3'h4, 2'h0, 3'h0, 3'h4,
                 3'h1, 8'h77, 4'h0}, 1'b0);
        complete_run();
    end
endmodule // iaa_top_test
